// ==== design/channel_ctrl_status_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Extended status bit 15 always reads one; writes ignored.
// - Extended status bits 14 to 0 read zero; writes ignored.
// - Global write set: bits 14:8 land in every channel at once.
// - Global write clear: only the addressed channel is updated.
// - Global write bit self clears, reads zero, resets to zero.
// - Amplitude bit, reset one: one full swing, zero half swing.
// - Compensation active only when register bit and strap both high.
// - Coding sublayer active only when register bit and strap both high.
// - Swap exchanges parallel interfaces of the two channels of a pair.
// - Swap acts on fixed pairs: first-second, third-fourth, fifth-sixth.
// - Swap active if register bit or swap strap high; bit resets zero.
// - Repeat sends partner's serial receive data instead of own transmit.
// - Repeat active if register bit or channel's relay strap high.
// - Shallow loopback only while standard bit and loop strap are low.
// - Shallow loopback returns parallel transmit to own parallel receive.
// - Far-end loopback returns serial receive to own serial transmit.
module channel_ctrl_status_regs
#(
    parameter int         CHANNELS = chan_regs_pkg::NUM_CHANNELS,
    parameter int         WORD     = chan_regs_pkg::WORD_W,
    parameter logic [4:0] PHY_BASE = chan_regs_pkg::PHY_BASE_DEFAULT
)
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    // Management interface pins
    input  wire logic                         mdc_pin,
    input  wire logic                         mdio_in,
    output logic                              mdio_out,
    output logic                              mdio_oe,
    // Strap pins
    input  wire logic                         clock_tolerance_comp_strap,
    input  wire logic                         code_enable_strap,
    input  wire logic                         swap_strap,
    input  wire logic                         relay_strap_first,
    input  wire logic                         relay_strap_second,
    input  wire logic                         external_loop_strap,
    // Standard loopback bit of each channel, same clock
    input  wire logic [CHANNELS-1:0]          std_loopback,
    // Datapath words
    input  wire logic [CHANNELS-1:0][WORD-1:0] parallel_tx_in,
    input  wire logic [CHANNELS-1:0][WORD-1:0] serial_in,
    output logic      [CHANNELS-1:0][WORD-1:0] serial_out,
    output logic      [CHANNELS-1:0][WORD-1:0] parallel_rx_out,
    // Effective controls
    output logic      [CHANNELS-1:0]          tx_full_swing,
    output logic      [CHANNELS-1:0]          comp_active,
    output logic      [CHANNELS-1:0]          pcs_active,
    output logic      [CHANNELS-1:0]          swap_active,
    output logic      [CHANNELS-1:0]          relay_active,
    output logic      [CHANNELS-1:0]          shallow_loop_active,
    output logic      [CHANNELS-1:0]          far_loop_active
);
    import chan_regs_pkg::*;

    if (CHANNELS < 2 || CHANNELS > 32 || (CHANNELS % 2) != 0) begin : g_bad_ch
        $error("CHANNELS must be even, 2 to 32");
    end
    if (WORD < 1) begin : g_bad_word
        $error("WORD must be at least one");
    end

    function automatic logic [5:0] chan_of(input logic [4:0] phy);
        return {1'b0, phy} - {1'b0, PHY_BASE};
    endfunction

    function automatic logic chan_in_range(input logic [4:0] phy);
        return (phy >= PHY_BASE) && (chan_of(phy) < 6'(CHANNELS));
    endfunction

    mgmt_req_if mgmt ();

    mdio_frame_engine u_engine (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .mdc_pin  (mdc_pin),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .mgmt     (mgmt)
    );

    // Straps are asynchronous pins: two flops before use
    logic [5:0] strap_s1_ff;
    logic [5:0] strap_s2_ff;

    always_ff @(posedge ref_clk) begin
        strap_s1_ff <= {clock_tolerance_comp_strap, code_enable_strap,
                        swap_strap, relay_strap_first,
                        relay_strap_second, external_loop_strap};
        strap_s2_ff <= strap_s1_ff;
    end

    wire comp_strap  = strap_s2_ff[5];
    wire code_strap  = strap_s2_ff[4];
    wire swap_pin    = strap_s2_ff[3];
    wire relay_a_pin = strap_s2_ff[2];
    wire relay_b_pin = strap_s2_ff[1];
    wire loop_pin    = strap_s2_ff[0];

    wire       acc_hit     = chan_in_range(mgmt.phy_addr);
    wire [5:0] acc_chan    = chan_of(mgmt.phy_addr);
    wire       is_ext_stat = (mgmt.reg_addr == EXT_STATUS_ADDR);
    wire       is_ctrl0    = (mgmt.reg_addr == CHAN_CTRL0_ADDR);
    wire       wr_ctrl0    = mgmt.req & mgmt.we & acc_hit & is_ctrl0;
    wire       wr_global   = mgmt.wdata[GLOBAL_WRITE_BIT];
    wire [CTRL_W-1:0] wr_field = mgmt.wdata[TX_AMP_BIT:FAR_LOOP_BIT];

    assign mgmt.hit = acc_hit;

    logic [CHANNELS-1:0][CTRL_W-1:0] ctrl_ff;
    logic [15:0]                     rdata_ff;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            wire sel = (acc_chan == 6'(g));
            wire upd = wr_ctrl0 & (wr_global | sel);

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    ctrl_ff[g] <= CTRL_RESET;
                end else if (upd) begin
                    ctrl_ff[g] <= wr_field;
                end
            end
        end
    endgenerate

    // Global write bit is never stored, so it reads zero
    wire [15:0] ctrl0_view = {1'b0, ctrl_ff[acc_chan[4:0]], 8'h00};
    wire [15:0] read_mux   = !acc_hit    ? 16'h0000 :
                             is_ext_stat ? EXT_STATUS_VALUE :
                             is_ctrl0    ? ctrl0_view :
                                           16'h0000;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= 16'h0000;
        end else if (mgmt.req & ~mgmt.we) begin
            rdata_ff <= read_mux;
        end
    end

    assign mgmt.rdata = rdata_ff;

    // Effective controls, recomputed every cycle
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_eff
            localparam int P = g ^ 1;
            wire [CTRL_W-1:0] c = ctrl_ff[g];
            wire relay_pin = (g % 2 == 0) ? relay_a_pin : relay_b_pin;

            assign tx_full_swing[g] = c[F_TX_AMP];
            assign comp_active[g]   = c[F_COMP] & comp_strap;
            assign pcs_active[g]    = c[F_PCS] & code_strap;
            // Either channel of a pair turns swap on for both
            assign swap_active[g]   = c[F_SWAP] | ctrl_ff[P][F_SWAP]
                                      | swap_pin;
            assign relay_active[g]  = c[F_RELAY] | relay_pin;
            assign shallow_loop_active[g] = c[F_SHALLOW]
                                      & ~std_loopback[g]
                                      & ~loop_pin;
            assign far_loop_active[g] = c[F_FAR_LOOP];
        end
    endgenerate

    logic [CHANNELS-1:0][WORD-1:0] stx_ff;
    logic [CHANNELS-1:0][WORD-1:0] prx_ff;

    generate
        for (g = 0; g < CHANNELS; g++) begin : g_path
            localparam int P = g ^ 1;
            wire [WORD-1:0] tx_src = swap_active[g] ? parallel_tx_in[P]
                                                    : parallel_tx_in[g];
            wire [WORD-1:0] rx_src = swap_active[g] ? serial_in[P]
                                                    : serial_in[g];
            // Far-end loopback overrides repeat and normal traffic
            wire [WORD-1:0] nxt_stx = far_loop_active[g] ? serial_in[g] :
                                      relay_active[g]    ? serial_in[P] :
                                                           tx_src;
            wire [WORD-1:0] nxt_prx = shallow_loop_active[g]
                                      ? parallel_tx_in[g]
                                      : rx_src;

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    stx_ff[g] <= '0;
                    prx_ff[g] <= '0;
                end else begin
                    stx_ff[g] <= nxt_stx;
                    prx_ff[g] <= nxt_prx;
                end
            end
        end
    endgenerate

    assign serial_out      = stx_ff;
    assign parallel_rx_out = prx_ff;

endmodule
`default_nettype wire

// ==== shared/chan_regs_pkg.sv ====
package chan_regs_pkg;

    // Register map
    localparam logic [4:0]  EXT_STATUS_ADDR    = 5'h0f;
    localparam logic [4:0]  CHAN_CTRL0_ADDR    = 5'h10;

    // Extended status contents
    localparam logic [15:0] EXT_STATUS_VALUE   = 16'h8000;

    // Control register 0 field positions
    localparam int          GLOBAL_WRITE_BIT   = 15;
    localparam int          TX_AMP_BIT         = 14;
    localparam int          COMP_BIT           = 13;
    localparam int          PCS_BIT            = 12;
    localparam int          SWAP_BIT           = 11;
    localparam int          RELAY_BIT          = 10;
    localparam int          SHALLOW_BIT        = 9;
    localparam int          FAR_LOOP_BIT       = 8;
    localparam int          CTRL_LSB           = 8;
    localparam int          CTRL_W             = 7;

    // Reset value of bits 14:8 (amplitude, compensation, coding set)
    localparam logic [6:0]  CTRL_RESET         = 7'h70;

    // Field index within the stored 7-bit copy
    localparam int          F_TX_AMP           = TX_AMP_BIT - CTRL_LSB;
    localparam int          F_COMP             = COMP_BIT - CTRL_LSB;
    localparam int          F_PCS              = PCS_BIT - CTRL_LSB;
    localparam int          F_SWAP             = SWAP_BIT - CTRL_LSB;
    localparam int          F_RELAY            = RELAY_BIT - CTRL_LSB;
    localparam int          F_SHALLOW          = SHALLOW_BIT - CTRL_LSB;
    localparam int          F_FAR_LOOP         = FAR_LOOP_BIT - CTRL_LSB;

    // Management frame layout
    localparam int          PREAMBLE_BITS      = 32;
    localparam int          HEADER_BITS        = 12;
    localparam int          DATA_BITS          = 16;
    localparam logic [1:0]  OP_READ            = 2'h2;
    localparam logic [1:0]  OP_WRITE           = 2'h1;

    // Defaults
    localparam int          NUM_CHANNELS       = 6;
    localparam int          WORD_W             = 10;
    localparam logic [4:0]  PHY_BASE_DEFAULT   = 5'h00;

endpackage

// ==== shared/mgmt_req_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface mgmt_req_if;
    logic        req;
    logic        we;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        hit;

    modport engine (
        output req,
        output we,
        output phy_addr,
        output reg_addr,
        output wdata,
        input  rdata,
        input  hit
    );

    modport bank (
        input  req,
        input  we,
        input  phy_addr,
        input  reg_addr,
        input  wdata,
        output rdata,
        output hit
    );
endinterface
`default_nettype wire

// ==== design/mdio_frame_engine.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdio_frame_engine
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Management pins
    input  wire logic mdc_pin,
    input  wire logic mdio_in,
    output logic      mdio_out,
    output logic      mdio_oe,
    // Request towards the register bank
    mgmt_req_if.engine mgmt
);
    import chan_regs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_HEADER,
        ST_TURN,
        ST_DATA
    } frame_state_e;

    frame_state_e state_ff;
    logic         mdc_s1_ff;
    logic         mdc_s2_ff;
    logic         mdc_prev_ff;
    logic         dat_s1_ff;
    logic         dat_s2_ff;
    logic [5:0]   ones_ff;
    logic [3:0]   cnt_ff;
    logic [15:0]  shift_ff;
    logic         is_rd_ff;
    logic         out_ff;
    logic         oe_ff;
    logic         req_ff;
    logic         we_ff;
    logic [4:0]   phy_ff;
    logic [4:0]   reg_ff;
    logic [15:0]  wdata_ff;

    wire          bit_rise   = mdc_s2_ff & ~mdc_prev_ff;
    wire          bit_in     = dat_s2_ff;
    wire [15:0]   nxt_shift  = {shift_ff[14:0], bit_in};
    wire [1:0]    hdr_op     = nxt_shift[11:10];
    wire          hdr_ok     = (hdr_op == OP_READ) || (hdr_op == OP_WRITE);
    wire          drive_rd   = is_rd_ff & mgmt.hit;
    wire          pre_done   = (ones_ff >= 6'(PREAMBLE_BITS));

    // Both pins pass two flops; clock and data keep equal delay
    always_ff @(posedge ref_clk) begin
        mdc_s1_ff   <= mdc_pin;
        mdc_s2_ff   <= mdc_s1_ff;
        mdc_prev_ff <= mdc_s2_ff;
        dat_s1_ff   <= mdio_in;
        dat_s2_ff   <= dat_s1_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            ones_ff  <= 6'h00;
            cnt_ff   <= 4'h0;
            shift_ff <= 16'h0000;
            is_rd_ff <= 1'b0;
            out_ff   <= 1'b1;
            oe_ff    <= 1'b0;
            req_ff   <= 1'b0;
            we_ff    <= 1'b0;
            phy_ff   <= 5'h00;
            reg_ff   <= 5'h00;
            wdata_ff <= 16'h0000;
        end else begin
            req_ff <= 1'b0;
            if (bit_rise) begin
                case (state_ff)
                    ST_IDLE: begin
                        if (bit_in) begin
                            if (!pre_done) begin
                                ones_ff <= ones_ff + 6'h01;
                            end
                        end else begin
                            ones_ff <= 6'h00;
                            if (pre_done) begin
                                state_ff <= ST_START;
                            end
                        end
                    end
                    ST_START: begin
                        cnt_ff   <= 4'h0;
                        state_ff <= bit_in ? ST_HEADER : ST_IDLE;
                    end
                    ST_HEADER: begin
                        shift_ff <= nxt_shift;
                        cnt_ff   <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'(HEADER_BITS - 1)) begin
                            cnt_ff   <= 4'h0;
                            is_rd_ff <= (hdr_op == OP_READ);
                            phy_ff   <= nxt_shift[9:5];
                            reg_ff   <= nxt_shift[4:0];
                            state_ff <= hdr_ok ? ST_TURN : ST_IDLE;
                            // Read data is fetched early, long before use
                            req_ff   <= (hdr_op == OP_READ);
                            we_ff    <= 1'b0;
                        end
                    end
                    ST_TURN: begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h0) begin
                            oe_ff  <= drive_rd;
                            out_ff <= 1'b0;
                        end else begin
                            cnt_ff   <= 4'h0;
                            state_ff <= ST_DATA;
                            out_ff   <= drive_rd ? mgmt.rdata[15] : 1'b1;
                            shift_ff <= {mgmt.rdata[14:0], 1'b0};
                        end
                    end
                    ST_DATA: begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (is_rd_ff) begin
                            out_ff   <= shift_ff[15];
                            shift_ff <= {shift_ff[14:0], 1'b0};
                        end else begin
                            shift_ff <= nxt_shift;
                        end
                        if (cnt_ff == 4'(DATA_BITS - 1)) begin
                            state_ff <= ST_IDLE;
                            oe_ff    <= 1'b0;
                            out_ff   <= 1'b1;
                            ones_ff  <= 6'h00;
                            req_ff   <= ~is_rd_ff;
                            we_ff    <= ~is_rd_ff;
                            wdata_ff <= nxt_shift;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign mdio_out      = out_ff;
    assign mdio_oe       = oe_ff;
    assign mgmt.req      = req_ff;
    assign mgmt.we       = we_ff;
    assign mgmt.phy_addr = phy_ff;
    assign mgmt.reg_addr = reg_ff;
    assign mgmt.wdata    = wdata_ff;

endmodule
`default_nettype wire

// ==== tb/chan_regs_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module chan_regs_checker
#(
    parameter int CHANNELS = chan_regs_pkg::NUM_CHANNELS,
    parameter int WORD     = chan_regs_pkg::WORD_W
)
(
    // Clock and reset
    input wire logic                          ref_clk,
    input wire logic                          reset,
    // Straps
    input wire logic                          clock_tolerance_comp_strap,
    input wire logic                          swap_strap,
    input wire logic                          relay_strap_first,
    input wire logic                          external_loop_strap,
    input wire logic [CHANNELS-1:0]           std_loopback,
    // Datapath
    input wire logic [CHANNELS-1:0][WORD-1:0] parallel_tx_in,
    input wire logic [CHANNELS-1:0][WORD-1:0] serial_in,
    input wire logic [CHANNELS-1:0][WORD-1:0] serial_out,
    input wire logic [CHANNELS-1:0][WORD-1:0] parallel_rx_out,
    // Effective controls
    input wire logic [CHANNELS-1:0]           tx_full_swing,
    input wire logic [CHANNELS-1:0]           comp_active,
    input wire logic [CHANNELS-1:0]           swap_active,
    input wire logic [CHANNELS-1:0]           relay_active,
    input wire logic [CHANNELS-1:0]           shallow_loop_active,
    input wire logic [CHANNELS-1:0]           far_loop_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [1:0] rst_hist_ff;
    wire        calm;
    always_ff @(posedge ref_clk) begin
        rst_hist_ff <= {rst_hist_ff[0], reset};
    end
    // Straps lag reset by two flops
    assign calm = (rst_hist_ff == 2'h0);
    a_amp_reset_full: assert property ($fell(reset) |-> &tx_full_swing)
        else $error("swing not full after reset");
    a_comp_needs_strap: assert property (calm && (|comp_active)
        |-> $past(clock_tolerance_comp_strap, 2)) else $error("comp no strap");
    a_swap_strap_or: assert property (calm && $past(swap_strap, 2)
        |-> &swap_active) else $error("swap strap ignored");
    a_swap_pair_fixed: assert property (swap_active[0] == swap_active[1])
        else $error("swap split across pair");
    a_relay_strap_or: assert property (calm && $past(relay_strap_first, 2)
        |-> relay_active[0]) else $error("relay strap ignored");
    a_shallow_std_low: assert property ((std_loopback & shallow_loop_active)
        == '0) else $error("shallow with standard loop");
    a_shallow_strap_low: assert property (calm
        && $past(external_loop_strap, 2) |-> shallow_loop_active == '0)
        else $error("shallow with loop strap");
    a_far_loop_route: assert property (calm && $past(far_loop_active[0])
        |-> serial_out[0] == $past(serial_in[0])) else $error("far loop data");
    a_relay_route: assert property (calm
        && $past(relay_active[0] && !far_loop_active[0])
        |-> serial_out[0] == $past(serial_in[1])) else $error("relay data");
    a_shallow_route: assert property (calm && $past(shallow_loop_active[1])
        |-> parallel_rx_out[1] == $past(parallel_tx_in[1]))
        else $error("shallow data");
    a_swap_route: assert property (calm
        && $past(swap_active[0] && !shallow_loop_active[0])
        |-> parallel_rx_out[0] == $past(serial_in[1])) else $error("swap data");
endmodule
bind channel_ctrl_status_regs chan_regs_checker #(
    .CHANNELS(CHANNELS), .WORD(WORD)) u_chk (.ref_clk, .reset,
    .clock_tolerance_comp_strap, .swap_strap, .relay_strap_first,
    .external_loop_strap, .std_loopback, .parallel_tx_in, .serial_in,
    .serial_out, .parallel_rx_out, .tx_full_swing, .comp_active,
    .swap_active, .relay_active, .shallow_loop_active, .far_loop_active);
`default_nettype wire

// ==== tb/mdio_station.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdio_station (
    // Clock and resolved wire
    input  wire logic ref_clk,
    input  wire logic line,
    // Station drive
    output logic      mdc,
    output logic      drv,
    output logic      drv_oe
);
    initial begin
        mdc = 1'b1;
        drv = 1'b1;
        drv_oe = 1'b0;
    end
    // Data moves while clock is low
    task automatic slot(input logic b, input logic oe, output logic s);
        mdc = 1'b0;
        drv = b;
        drv_oe = oe;
        repeat (8) @(negedge ref_clk);
        s = line;
        mdc = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] p,
        input logic [4:0] r, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] w;
        logic        s;
        w = {2'h1, op, p, r, 2'h2, wd};
        for (int i = 0; i < 32; i++)
            slot(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            slot(w[i], (i > 17) || (op == 2'h1), s);
            if (i < 16)
                rd[i] = s;
        end
        drv_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_channel_ctrl_status_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_channel_ctrl_status_regs;
    import chan_regs_pkg::*;
    localparam int CH = 6;
    logic ref_clk, reset, mdc, drv, drv_oe, mdio_out, mdio_oe, line;
    logic clock_tolerance_comp_strap, code_enable_strap, swap_strap;
    logic relay_strap_first, relay_strap_second, external_loop_strap;
    logic [CH-1:0][WORD_W-1:0] parallel_tx_in, serial_in;
    logic [CH-1:0][WORD_W-1:0] serial_out, parallel_rx_out;
    logic [CH-1:0] std_loopback, tx_full_swing, comp_active, pcs_active;
    logic [CH-1:0] swap_active, relay_active, shallow_loop_active;
    logic [CH-1:0] far_loop_active;
    int            n_errors, tests_run, cyc;
    // Pull-up holds the wire high when nobody drives it
    assign line = mdio_oe ? mdio_out : (drv_oe ? drv : 1'b1);
    channel_ctrl_status_regs #(.CHANNELS(CH)) uut (.ref_clk, .reset,
        .mdc_pin(mdc), .mdio_in(line), .mdio_out, .mdio_oe,
        .clock_tolerance_comp_strap, .code_enable_strap, .swap_strap,
        .relay_strap_first, .relay_strap_second, .external_loop_strap,
        .std_loopback, .parallel_tx_in, .serial_in, .serial_out,
        .parallel_rx_out, .tx_full_swing, .comp_active, .pcs_active,
        .swap_active, .relay_active, .shallow_loop_active, .far_loop_active);
    mdio_station st (.ref_clk, .line, .mdc, .drv, .drv_oe);
    always #10 ref_clk = ~ref_clk;
    function automatic logic [9:0] tw(int c);
        return 10'h100 + 10'(c);
    endfunction
    function automatic logic [9:0] rw(int c);
        return 10'h200 + 10'(c);
    endfunction
    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_reg(string n, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_vec(string n, logic [CH-1:0] e, logic [CH-1:0] s);
        chk_reg(n, 16'(e), 16'(s));
    endtask
    task automatic chk_word(string n, logic [9:0] e, logic [9:0] s);
        chk_reg(n, 16'(e), 16'(s));
    endtask
    task automatic wr(logic [4:0] p, logic [4:0] r, logic [15:0] d);
        logic [15:0] v;
        st.frame(OP_WRITE, p, r, d, v);
    endtask
    task automatic rd(logic [4:0] p, logic [4:0] r, output logic [15:0] v);
        st.frame(OP_READ, p, r, 16'h0, v);
    endtask
    task automatic t_reset();
        logic [15:0] v;
        rd(5'h0, EXT_STATUS_ADDR, v);
        chk_reg("ext status", 16'h8000, v);
        rd(5'h4, CHAN_CTRL0_ADDR, v);
        chk_reg("ctrl reset", 16'h7000, v);
        chk_vec("swing", 6'h3f, tx_full_swing);
        chk_vec("comp", 6'h3f, comp_active);
        chk_vec("pcs", 6'h3f, pcs_active);
        for (int c = 0; c < CH; c++)
            chk_word("plain out", tw(c), serial_out[c]);
    endtask
    task automatic t_ext_ro();
        logic [15:0] v;
        wr(5'h1, EXT_STATUS_ADDR, 16'h7fff);
        rd(5'h1, EXT_STATUS_ADDR, v);
        chk_reg("ext written", 16'h8000, v);
    endtask
    task automatic t_refuse();
        logic [15:0] v;
        wr(5'h6, CHAN_CTRL0_ADDR, 16'h0000);
        rd(5'h5, CHAN_CTRL0_ADDR, v);
        chk_reg("far phy write", 16'h7000, v);
        rd(5'h7, CHAN_CTRL0_ADDR, v);
        chk_reg("far phy read", 16'hffff, v);
        st.frame(2'h0, 5'h0, CHAN_CTRL0_ADDR, 16'h0000, v);
        rd(5'h0, CHAN_CTRL0_ADDR, v);
        chk_reg("bad op", 16'h7000, v);
        rd(5'h0, 5'h05, v);
        chk_reg("unmapped", 16'h0000, v);
    endtask
    task automatic t_local();
        logic [15:0] v;
        wr(5'h3, CHAN_CTRL0_ADDR, 16'h0000);
        rd(5'h3, CHAN_CTRL0_ADDR, v);
        chk_reg("own chan", 16'h0000, v);
        rd(5'h2, CHAN_CTRL0_ADDR, v);
        chk_reg("other chan", 16'h7000, v);
        chk_vec("swing", 6'h37, tx_full_swing);
        chk_vec("comp", 6'h37, comp_active);
        chk_vec("pcs", 6'h37, pcs_active);
    endtask
    task automatic t_global();
        logic [15:0] v;
        wr(5'h1, CHAN_CTRL0_ADDR, 16'h8a00);
        rd(5'h5, CHAN_CTRL0_ADDR, v);
        chk_reg("global", 16'h0a00, v);
        chk_vec("swap", 6'h3f, swap_active);
        chk_vec("shallow", 6'h3f, shallow_loop_active);
        for (int c = 0; c < CH; c++) begin
            chk_word("shallow rx", tw(c), parallel_rx_out[c]);
            chk_word("swap tx", tw(c ^ 1), serial_out[c]);
        end
        std_loopback = 6'h3f;
        repeat (2) @(negedge ref_clk);
        chk_vec("shallow std", 6'h00, shallow_loop_active);
        for (int c = 0; c < CH; c++)
            chk_word("swap rx", rw(c ^ 1), parallel_rx_out[c]);
        std_loopback = 6'h00;
    endtask
    task automatic t_straps();
        wr(5'h0, CHAN_CTRL0_ADDR, 16'hf000);
        clock_tolerance_comp_strap = 1'b0;
        code_enable_strap = 1'b0;
        swap_strap = 1'b1;
        relay_strap_first = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk_vec("comp strap", 6'h00, comp_active);
        chk_vec("pcs strap", 6'h00, pcs_active);
        chk_vec("swap strap", 6'h3f, swap_active);
        chk_vec("relay even", 6'h15, relay_active);
        chk_word("relay out", rw(1), serial_out[0]);
        chk_word("swap out", tw(0), serial_out[1]);
        relay_strap_second = 1'b1;
        external_loop_strap = 1'b1;
        wr(5'h0, CHAN_CTRL0_ADDR, 16'hf200);
        chk_vec("relay odd", 6'h3f, relay_active);
        chk_vec("shallow strap", 6'h00, shallow_loop_active);
        {clock_tolerance_comp_strap, code_enable_strap} = 2'h3;
        {swap_strap, relay_strap_first, relay_strap_second} = 3'h0;
        external_loop_strap = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk_vec("shallow back", 6'h3f, shallow_loop_active);
    endtask
    task automatic t_far();
        wr(5'h0, CHAN_CTRL0_ADDR, 16'hf000);
        wr(5'h0, CHAN_CTRL0_ADDR, 16'h7500);
        wr(5'h1, CHAN_CTRL0_ADDR, 16'h7400);
        chk_vec("far", 6'h01, far_loop_active);
        chk_vec("relay reg", 6'h03, relay_active);
        chk_word("far out", rw(0), serial_out[0]);
        chk_word("relay out", rw(0), serial_out[1]);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {ref_clk, reset, swap_strap, external_loop_strap} = 4'h4;
        {clock_tolerance_comp_strap, code_enable_strap} = 2'h3;
        {relay_strap_first, relay_strap_second} = 2'h0;
        std_loopback = 6'h00;
        for (int c = 0; c < CH; c++) begin
            parallel_tx_in[c] = tw(c);
            serial_in[c] = rw(c);
        end
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_ext_ro();
        t_refuse();
        t_local();
        t_global();
        t_straps();
        t_far();
        end_of_test();
    end
endmodule
`default_nettype wire
